// ==== epc_pkg.sv ====
// Package for the EPROM programming control block
`default_nettype none
package epc_pkg;
  // Register map, byte addresses on the register bus
  localparam logic [7:0] EPROM_PROGRAM_CONTROL_OFFS = 8'h1c;
  localparam logic [7:0] OPTION_BYTE_REG_LO_OFFS    = 8'h20;
  localparam logic [7:0] OPTION_BYTE_REG_HI_OFFS    = 8'h24;
  localparam logic [7:0] BOOT_STATUS_OFFS           = 8'h28;
  localparam logic [7:0] BOOT_CONTROL_OFFS          = 8'h2c;
  // Field positions in the programming control register
  localparam int LATCH_BIT_POS = 2;
  localparam int POWER_BIT_POS = 0;
  localparam logic [7:0] EPROM_PROGRAM_CONTROL_RESET = 8'h00;
  // Array geometry
  localparam int ARRAY_ADDR_W = 13;
  localparam logic [12:0] OPTION_ADDR_LO = 13'h1eff;
  localparam logic [12:0] OPTION_ADDR_HI = 13'h1f00;
  localparam logic [7:0]  OPTION_RESET   = 8'h00;
  // Programming pulse time in microseconds and its cycle count at 200 MHz
  localparam int CLK_MHZ              = 200;
  localparam int PROGRAM_PULSE_TIME_US = 4000;
  localparam int PROGRAM_PULSE_CYCLES = PROGRAM_PULSE_TIME_US * CLK_MHZ;
  // Boot modes from {high, mid, low} mode pins
  typedef enum logic [1:0] {
    EPC_BOOT_NONE   = 2'b00,
    EPC_BOOT_PGMVFY = 2'b01,
    EPC_BOOT_VERIFY = 2'b11,
    EPC_BOOT_DUMP   = 2'b10
  } epc_boot_mode_t;
  localparam logic [2:0] PINS_PGMVFY = 3'b111;
  localparam logic [2:0] PINS_VERIFY = 3'b110;
  localparam logic [2:0] PINS_DUMP   = 3'b100;
  // CPU write or read toward the array
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [ARRAY_ADDR_W-1:0] addr;
    logic [7:0]              data;
  } epc_array_req_t;
  // Programming latches and power toward the array
  typedef struct packed {
    logic                    prog_cfg;
    logic                    power;
    logic                    latched;
    logic [ARRAY_ADDR_W-1:0] addr;
    logic [7:0]              data;
  } epc_array_ctl_t;
endpackage
`default_nettype wire

// ==== epc_boot_decode.sv ====
// Boot mode decoder with indicator outputs
`default_nettype none
module epc_boot_decode (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Mode pins
  input  wire logic              boot_mode_pin_high,
  input  wire logic              boot_mode_pin_mid,
  input  wire logic              boot_mode_pin_low,
  // Progress from firmware
  input  wire logic              programming,
  input  wire logic              verify_pass,
  // Decoded mode and indicators
  output epc_pkg::epc_boot_mode_t mode,
  output logic                   program_led,
  output logic                   verify_led
);
  typedef struct packed {
    epc_pkg::epc_boot_mode_t mode;
    logic                    pled;
    logic                    vled;
  } epc_bd_state_t;
  epc_bd_state_t s_r;
  epc_bd_state_t s_nxt;

  function automatic epc_pkg::epc_boot_mode_t decode(input logic [2:0] p);
    unique case (p)
      epc_pkg::PINS_PGMVFY: decode = epc_pkg::EPC_BOOT_PGMVFY;
      epc_pkg::PINS_VERIFY: decode = epc_pkg::EPC_BOOT_VERIFY;
      epc_pkg::PINS_DUMP:   decode = epc_pkg::EPC_BOOT_DUMP;
      default:              decode = epc_pkg::EPC_BOOT_NONE;
    endcase
  endfunction

  always_comb begin
    s_nxt      = s_r;
    s_nxt.mode = decode({boot_mode_pin_high, boot_mode_pin_mid, boot_mode_pin_low});
    s_nxt.pled = programming && (s_r.mode == epc_pkg::EPC_BOOT_PGMVFY);
    // Verify lamp only when verification was asked for
    s_nxt.vled = verify_pass && (s_r.mode == epc_pkg::EPC_BOOT_PGMVFY
                                 || s_r.mode == epc_pkg::EPC_BOOT_VERIFY);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '{mode: epc_pkg::EPC_BOOT_NONE, pled: 1'b0, vled: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mode        = s_r.mode;
  assign program_led = s_r.pled;
  assign verify_led  = s_r.vled;

  chk_vled_needs_mode: assert property (@(posedge clk) disable iff (reset)
    verify_led |-> $past(s_r.mode) != epc_pkg::EPC_BOOT_DUMP)
    else $error("verify lamp lit in dump mode");
endmodule
`default_nettype wire

// ==== epc_top.sv ====
// EPROM programming control block with APB register slave
`default_nettype none
// Summary of operation
// - Power bit set drives programming power onto the array; clear withdraws it.
// - Power bit can be set only when latch bit was already set.
// - Clearing latch bit, by write or reset, clears power bit too.
// - Setting both bits in one write sets latch, leaves power clear.
// - Both bits readable and writable any time; reads show current state.
// - Reset clears every bit of the programming control register.
// - Latch bit set puts array address and data paths in program configuration.
// - With latch set, next CPU array write captures address and data.
// - With latch set, array reads do not return stored contents.
// - Mode pins high, mid, low: 111 program/verify, 110 verify, 100 dump.
// - Program lamp lit while programming in program/verify mode only; verify lamp only on requested pass.
// - Two option bytes configure seven device features.
// - New option byte values reach live option registers only after reset.
module epc_top #(
  parameter int PULSE_CYCLES = epc_pkg::PROGRAM_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // CPU path toward the array
  input  wire epc_pkg::epc_array_req_t cpu_req,
  input  wire logic [7:0]             array_rdata,
  output logic [7:0]                  cpu_rdata,
  output epc_pkg::epc_array_ctl_t     array_ctl,
  // Bootloader pins and indicators
  input  wire logic                   boot_mode_pin_high,
  input  wire logic                   boot_mode_pin_mid,
  input  wire logic                   boot_mode_pin_low,
  input  wire logic                   boot_source_select_pin,
  output logic                        program_led,
  output logic                        verify_led,
  // Live option bytes
  output logic [15:0]                 option_live
);
  // Elaboration checks on what the logic can serve
  if (PULSE_CYCLES < 1) begin : g_bad_pulse
    $error("PULSE_CYCLES must be at least one");
  end
  if (epc_pkg::ARRAY_ADDR_W != 13) begin : g_bad_addr
    $error("array address must be 13 bits");
  end

  typedef struct packed {
    logic                            latch;
    logic                            power;
    epc_pkg::epc_array_ctl_t         ctl;
    logic [7:0]                      rdata;
    logic [7:0]                      opt_lo;
    logic [7:0]                      opt_hi;
    logic [15:0]                     live;
    logic                            loaded;
    logic [31:0]                     pulse_cnt;
    logic                            pulse_met;
    logic                            boot_prog;
    logic                            boot_pass;
    logic                            pready;
    logic [31:0]                     prdata;
    logic                            pslverr;
  } epc_state_t;
  epc_state_t s_r;
  epc_state_t s_nxt;

  epc_pkg::epc_boot_mode_t boot_mode;
  logic                    boot_pled;
  logic                    boot_vled;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS)
             || (a == epc_pkg::OPTION_BYTE_REG_LO_OFFS)
             || (a == epc_pkg::OPTION_BYTE_REG_HI_OFFS)
             || (a == epc_pkg::BOOT_STATUS_OFFS)
             || (a == epc_pkg::BOOT_CONTROL_OFFS);
  endfunction

  wire logic setup_wr = psel && !penable && pwrite;
  wire logic setup_rd = psel && !penable && !pwrite;

  always_comb begin
    logic w_latch;
    logic w_power;
    w_latch = pwdata[epc_pkg::LATCH_BIT_POS];
    w_power = pwdata[epc_pkg::POWER_BIT_POS];
    s_nxt          = s_r;
    s_nxt.pready   = 1'b0;
    s_nxt.pslverr  = 1'b0;
    // No wait state: answer lands in the first access-phase cycle
    if (psel && !penable) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !is_mapped(paddr);
      s_nxt.prdata  = 32'h0000_0000;
    end
    if (setup_wr && paddr == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS) begin
      s_nxt.latch = w_latch;
      // Power needs the latch set before this write; a fresh latch keeps power low
      s_nxt.power = w_power && s_r.latch && w_latch;
    end
    if (setup_wr && paddr == epc_pkg::BOOT_CONTROL_OFFS) begin
      s_nxt.boot_prog = pwdata[0];
      s_nxt.boot_pass = pwdata[1];
    end
    if (setup_rd) begin
      unique case (paddr)
        epc_pkg::EPROM_PROGRAM_CONTROL_OFFS: begin
          // Only two bits exist; the rest read zero
          s_nxt.prdata[epc_pkg::LATCH_BIT_POS] = s_r.latch;
          s_nxt.prdata[epc_pkg::POWER_BIT_POS] = s_r.power;
        end
        epc_pkg::OPTION_BYTE_REG_LO_OFFS: s_nxt.prdata = {24'h00_0000, s_r.live[7:0]};
        epc_pkg::OPTION_BYTE_REG_HI_OFFS: s_nxt.prdata = {24'h00_0000, s_r.live[15:8]};
        epc_pkg::BOOT_STATUS_OFFS: s_nxt.prdata = {24'h00_0000,
          1'b0, boot_source_select_pin, boot_mode, boot_vled, boot_pled,
          s_r.pulse_met, s_r.ctl.latched};
        epc_pkg::BOOT_CONTROL_OFFS: s_nxt.prdata = {30'h0000_0000, s_r.boot_pass,
                                                    s_r.boot_prog};
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end
    // Capture only the first write after the latch bit goes high
    if (!s_r.latch) begin
      s_nxt.ctl.latched = 1'b0;
    end else if (cpu_req.wr && !s_r.ctl.latched) begin
      s_nxt.ctl.latched = 1'b1;
      s_nxt.ctl.addr    = cpu_req.addr;
      s_nxt.ctl.data    = cpu_req.data;
    end
    // Programming a byte into the option shadows; live copy waits for reset
    if (s_r.power && s_r.ctl.latched) begin
      if (s_r.ctl.addr == epc_pkg::OPTION_ADDR_LO) begin
        s_nxt.opt_lo = s_r.ctl.data;
      end else if (s_r.ctl.addr == epc_pkg::OPTION_ADDR_HI) begin
        s_nxt.opt_hi = s_r.ctl.data;
      end
    end
    if (!s_r.loaded) begin
      s_nxt.live   = {s_r.opt_hi, s_r.opt_lo};
      s_nxt.loaded = 1'b1;
    end
    // Pulse length monitor for software, saturating
    if (!s_r.power) begin
      s_nxt.pulse_cnt = 32'h0000_0000;
      s_nxt.pulse_met = 1'b0;
    end else if (s_r.pulse_cnt < 32'(PULSE_CYCLES)) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt + 32'h0000_0001;
    end else begin
      s_nxt.pulse_met = 1'b1;
    end
    s_nxt.ctl.prog_cfg = s_nxt.latch;
    s_nxt.ctl.power    = s_nxt.power;
    // Reads of the array are blanked while latched
    s_nxt.rdata = s_nxt.latch ? 8'h00 : array_rdata;

    // Option shadows stand for nonvolatile cells, so reset spares them
    if (reset) begin
      s_nxt        = '0;
      s_nxt.opt_lo = s_r.opt_lo;
      s_nxt.opt_hi = s_r.opt_hi;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  epc_boot_decode u_boot (
    .clk                (clk),
    .reset              (reset),
    .boot_mode_pin_high (boot_mode_pin_high),
    .boot_mode_pin_mid  (boot_mode_pin_mid),
    .boot_mode_pin_low  (boot_mode_pin_low),
    .programming        (s_r.boot_prog),
    .verify_pass        (s_r.boot_pass),
    .mode               (boot_mode),
    .program_led        (boot_pled),
    .verify_led         (boot_vled)
  );

  assign pready      = s_r.pready;
  assign prdata      = s_r.prdata;
  assign pslverr     = s_r.pslverr;
  assign array_ctl   = s_r.ctl;
  assign cpu_rdata   = s_r.rdata;
  assign program_led = boot_pled;
  assign verify_led  = boot_vled;
  assign option_live = s_r.live;

  chk_power_needs_latch: assert property (@(posedge clk) disable iff (reset)
    s_r.power |-> s_r.latch)
    else $error("power bit set without latch bit");
  chk_both_set_write: assert property (@(posedge clk) disable iff (reset)
    (setup_wr && paddr == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS && !s_r.latch)
    |=> s_r.latch == $past(pwdata[epc_pkg::LATCH_BIT_POS]) && !s_r.power)
    else $error("power set on same write as latch");
  chk_latch_clear_power: assert property (@(posedge clk) disable iff (reset)
    $fell(s_r.latch) |-> !s_r.power && !array_ctl.power)
    else $error("power survived latch clear");
  chk_power_follows: assert property (@(posedge clk) disable iff (reset)
    array_ctl.power == s_r.power)
    else $error("array power differs from power bit");
  chk_read_blank: assert property (@(posedge clk) disable iff (reset)
    s_r.latch && array_ctl.prog_cfg |-> cpu_rdata == 8'h00)
    else $error("array data visible while latched");
  chk_capture_once: assert property (@(posedge clk) disable iff (reset)
    (s_r.latch && cpu_req.wr && !array_ctl.latched && s_nxt.latch)
    |=> array_ctl.latched && array_ctl.addr == $past(cpu_req.addr))
    else $error("latched address not captured");
  chk_reg_readback: assert property (@(posedge clk) disable iff (reset)
    (setup_rd && paddr == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS)
    |=> prdata == {29'h0000_0000, $past(s_r.latch), 1'b0, $past(s_r.power)} && pready)
    else $error("control register read mismatch");
  chk_reset_clear: assert property (@(posedge clk)
    $past(reset) |-> !s_r.latch && !s_r.power)
    else $error("control bits not cleared by reset");
  chk_upper_zero: assert property (@(posedge clk) disable iff (reset)
    (setup_rd && paddr == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS) |=> prdata[31:3] == '0)
    else $error("unimplemented bits read nonzero");

  // Register bus handshake
  chk_ready_one_cycle: assert property (@(posedge clk) disable iff (reset)
    pready |=> !pready)
    else $error("ready stood two cycles");

  chk_ready_after_setup: assert property (@(posedge clk) disable iff (reset)
    (psel && !penable) |=> pready)
    else $error("no ready after setup");

  chk_ready_needs_setup: assert property (@(posedge clk) disable iff (reset)
    pready |-> $past(psel && !penable))
    else $error("ready without setup");

  chk_slverr_with_ready: assert property (@(posedge clk) disable iff (reset)
    pslverr |-> pready)
    else $error("error flag without ready");

  chk_slverr_unmapped: assert property (@(posedge clk) disable iff (reset)
    (psel && !penable && !is_mapped(paddr)) |=> pslverr)
    else $error("unmapped access not flagged");

  chk_slverr_mapped: assert property (@(posedge clk) disable iff (reset)
    (psel && !penable && is_mapped(paddr)) |=> !pslverr)
    else $error("mapped access flagged");

  chk_unmapped_no_write: assert property (@(posedge clk) disable iff (reset)
    (setup_wr && !is_mapped(paddr)) |=> s_r.latch == $past(s_r.latch))
    else $error("unmapped write changed latch");

  chk_unmapped_read_zero: assert property (@(posedge clk) disable iff (reset)
    (setup_rd && !is_mapped(paddr)) |=> prdata == 32'h0000_0000)
    else $error("unmapped read nonzero");

  chk_bit_one_zero: assert property (@(posedge clk) disable iff (reset)
    (setup_rd && paddr == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS) |=> !prdata[1])
    else $error("unused control bit read one");

  // Control bits
  chk_latch_write: assert property (@(posedge clk) disable iff (reset)
    (setup_wr && paddr == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS)
    |=> s_r.latch == $past(pwdata[epc_pkg::LATCH_BIT_POS]))
    else $error("latch bit not written");

  chk_latch_hold: assert property (@(posedge clk) disable iff (reset)
    (s_r.latch && !(setup_wr && paddr == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS)) |=> s_r.latch)
    else $error("latch bit lost without write");

  chk_power_refused: assert property (@(posedge clk) disable iff (reset)
    (setup_wr && paddr == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS && !s_r.latch) |=> !s_r.power)
    else $error("power set without prior latch");

  chk_power_taken: assert property (@(posedge clk) disable iff (reset)
    (setup_wr && paddr == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS && s_r.latch
     && pwdata[epc_pkg::POWER_BIT_POS] && pwdata[epc_pkg::LATCH_BIT_POS]) |=> s_r.power)
    else $error("legal power write ignored");

  chk_power_hold: assert property (@(posedge clk) disable iff (reset)
    (s_r.power && !(setup_wr && paddr == epc_pkg::EPROM_PROGRAM_CONTROL_OFFS)) |=> s_r.power)
    else $error("power bit lost without write");

  chk_prog_cfg_latch: assert property (@(posedge clk) disable iff (reset)
    array_ctl.prog_cfg == s_r.latch)
    else $error("program configuration differs from latch");

  // Array capture and read path
  chk_no_capture_unlatched: assert property (@(posedge clk) disable iff (reset)
    $past(!s_r.latch) |-> !array_ctl.latched)
    else $error("capture flag without latch");

  chk_capture_holds: assert property (@(posedge clk) disable iff (reset)
    (array_ctl.latched && s_r.latch) |=> array_ctl.addr == $past(array_ctl.addr)
    && array_ctl.data == $past(array_ctl.data))
    else $error("captured byte overwritten");

  chk_read_open: assert property (@(posedge clk) disable iff (reset)
    ($past(s_r.loaded) && !s_r.latch) |-> cpu_rdata == $past(array_rdata))
    else $error("array data not passed when unlatched");

  // Pulse monitor
  chk_pulse_clear: assert property (@(posedge clk) disable iff (reset)
    !s_r.power |=> !s_r.pulse_met && s_r.pulse_cnt == 32'h0000_0000)
    else $error("pulse monitor not cleared");

  chk_pulse_met_power: assert property (@(posedge clk) disable iff (reset)
    s_r.pulse_met |-> $past(s_r.power))
    else $error("pulse met without power");

  chk_pulse_bound: assert property (@(posedge clk) disable iff (reset)
    s_r.pulse_cnt <= 32'(PULSE_CYCLES))
    else $error("pulse count past its limit");

  // Option bytes and boot control
  chk_option_lo_prog: assert property (@(posedge clk) disable iff (reset)
    (s_r.power && s_r.ctl.latched && s_r.ctl.addr == epc_pkg::OPTION_ADDR_LO)
    |=> s_r.opt_lo == $past(s_r.ctl.data))
    else $error("low option shadow not programmed");

  chk_option_hi_prog: assert property (@(posedge clk) disable iff (reset)
    (s_r.power && s_r.ctl.latched && s_r.ctl.addr == epc_pkg::OPTION_ADDR_HI)
    |=> s_r.opt_hi == $past(s_r.ctl.data))
    else $error("high option shadow not programmed");

  chk_option_no_power: assert property (@(posedge clk) disable iff (reset)
    !s_r.power |=> $stable(s_r.opt_lo) && $stable(s_r.opt_hi))
    else $error("option shadow changed without power");

  chk_live_stable: assert property (@(posedge clk) disable iff (reset)
    $past(s_r.loaded) |-> $stable(option_live))
    else $error("live options changed without reset");

  chk_live_reload: assert property (@(posedge clk) disable iff (reset)
    (s_r.loaded && !$past(s_r.loaded)) |-> option_live == {$past(s_r.opt_hi), $past(s_r.opt_lo)})
    else $error("live options not reloaded after reset");

  chk_boot_ctl_write: assert property (@(posedge clk) disable iff (reset)
    (setup_wr && paddr == epc_pkg::BOOT_CONTROL_OFFS)
    |=> s_r.boot_prog == $past(pwdata[0]) && s_r.boot_pass == $past(pwdata[1]))
    else $error("boot control not written");
endmodule
`default_nettype wire

// ==== epc_array_model.sv ====
// Behavioural EPROM array and programming fixture beside the block
`default_nettype none
module epc_array_model (
  // Clock
  input  wire logic                    clk,
  // Array side of the block
  input  wire epc_pkg::epc_array_req_t cpu_req,
  input  wire epc_pkg::epc_array_ctl_t array_ctl,
  output logic [7:0]                   array_rdata,
  // Fixture pin
  output logic                         boot_source_select_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // 8 K image: a 12-bit counter spans 4 K, one port line picks the half
  logic [7:0] mem [0:8191];
  logic [7:0] junk_r;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    junk_r = 8'h5a;
  end
  // Copying from external memory keeps this pin low
  assign boot_source_select_pin = 1'b0;
  // Erased bits read 0; only power plus a captured byte sets them
  always @(posedge clk) begin
    junk_r <= ~junk_r;
    if (array_ctl.power && array_ctl.latched) begin
      mem[array_ctl.addr] <= mem[array_ctl.addr] | array_ctl.data;
    end
  end
  // Outside a read the bus changes every cycle so stale data never matches
  assign array_rdata = cpu_req.rd ? mem[cpu_req.addr] : junk_r;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench of the EPROM programming control block
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  $display("wrong value %s expected %h seen %h", nm, e, g); bad_count++; end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PULSE = 20;
  logic                    clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]              paddr, array_rdata, cpu_rdata, crd;
  logic [31:0]             pwdata, prdata, rd;
  epc_pkg::epc_array_req_t cpu_req;
  epc_pkg::epc_array_ctl_t array_ctl;
  logic                    pin_h, pin_m, pin_l, src_pin, program_led, verify_led;
  logic [15:0]             option_live;
  logic [2:0]              ctl_exp;
  int                      bad_count, check_count, seed;
  logic [2:0]              pins [3] = '{3'b111, 3'b110, 3'b100};
  logic [1:0]              codes [3] = '{2'b01, 2'b11, 2'b10};

  epc_top #(.PULSE_CYCLES(PULSE)) dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cpu_req(cpu_req), .array_rdata(array_rdata),
    .cpu_rdata(cpu_rdata), .array_ctl(array_ctl), .boot_mode_pin_high(pin_h),
    .boot_mode_pin_mid(pin_m), .boot_mode_pin_low(pin_l), .boot_source_select_pin(src_pin),
    .program_led(program_led), .verify_led(verify_led), .option_live(option_live));
  epc_array_model partner (.clk(clk), .cpu_req(cpu_req), .array_ctl(array_ctl),
    .array_rdata(array_rdata), .boot_source_select_pin(src_pin));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // Expected control state: power needs latch before and after the write
  function automatic logic [2:0] next_ctl(input logic [2:0] old, input logic [31:0] w);
    return {w[2], 1'b0, w[0] & old[2] & w[2]};
  endfunction

  task summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task do_reset;
    // Supplies come up while reset is held, then reset lets go
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    ctl_exp = 3'b000;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        summarize();
      end
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task ctl_wr(input logic [31:0] d);
    apb(1'b1, 8'h1c, d);
    ctl_exp = next_ctl(ctl_exp, d);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    `CHK("control", {29'h0000_0000, ctl_exp}, rd)
    `CHK("power out", ctl_exp[0], array_ctl.power)
    `CHK("prog cfg", ctl_exp[2], array_ctl.prog_cfg)
  endtask

  // One-cycle array access; read data is looked at one edge later
  task cpu(input logic w, input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    cpu_req <= '{w, !w, a, d};
    @(posedge clk);
    cpu_req <= '0;
    #1 crd = cpu_rdata;
  endtask

  initial begin
    seed = 66813;
    bad_count = 0;
    check_count = 0;
    {reset, psel, penable, pwrite, paddr, pwdata} = '0;
    cpu_req = '0;
    {pin_h, pin_m, pin_l} = 3'b000;
    do_reset();
    apb(1'b0, 8'h1c, 32'h0000_0000);
    `CHK("control at reset", 32'h0000_0000, rd)
    ctl_wr(32'h0000_0001);
    ctl_wr(32'hffff_ffff);
    ctl_wr(32'h0000_0005);
    ctl_wr(32'h0000_0001);
    $display("control bit test done");
    cpu(1'b1, 13'h0700, 8'h55);
    `CHK("no capture unlatched", 1'b0, array_ctl.latched)
    ctl_wr(32'h0000_0004);
    cpu(1'b1, 13'h0700, 8'h55);
    `CHK("capture", {1'b1, 13'h0700, 8'h55}, {array_ctl.latched, array_ctl.addr, array_ctl.data})
    cpu(1'b0, 13'h0700, 8'h00);
    `CHK("read while latched", 8'h00, crd)
    ctl_wr(32'h0000_0005);
    repeat (PULSE + 2) @(posedge clk);
    apb(1'b0, 8'h28, 32'h0000_0000);
    `CHK("pulse met and latched", 2'b11, rd[1:0])
    ctl_wr(32'h0000_0000);
    cpu(1'b0, 13'h0700, 8'h00);
    `CHK("array read back", 8'h55, crd)
    $display("byte program test done");
    apb(1'b1, 8'h2c, 32'h0000_0003);
    for (int i = 0; i < 3; i++) begin
      {pin_h, pin_m, pin_l} <= pins[i];
      repeat (4) @(posedge clk);
      apb(1'b0, 8'h28, 32'h0000_0000);
      `CHK("boot mode", codes[i], rd[5:4])
      `CHK("lamps", {i < 2, i == 0}, {verify_led, program_led})
      `CHK("source pin", 1'b0, rd[6])
    end
    $display("boot mode test done");
    ctl_wr(32'h0000_0004);
    cpu(1'b1, 13'h1eff, 8'ha5);
    ctl_wr(32'h0000_0005);
    repeat (PULSE) @(posedge clk);
    `CHK("option before reset", 16'h0000, option_live)
    ctl_wr(32'h0000_0004);
    do_reset();
    repeat (2) @(posedge clk);
    `CHK("option after reset", 16'h00a5, option_live)
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("option lo reg", 32'h0000_00a5, rd)
    apb(1'b0, 8'h1c, 32'h0000_0000);
    `CHK("control after reset", 32'h0000_0000, rd)
    $display("option byte test done");
    apb(1'b1, 8'h40, 32'hffff_ffff);
    `CHK("unmapped write err", 1'b1, err)
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmapped read", 33'h1_0000_0000, {err, rd})
    repeat (40) ctl_wr($random(seed));
    $display("random control test done");
    summarize();
  end
endmodule
`default_nettype wire
